// ==== hdl/lcdid_core.sv ====
// Local design decisions: the address map and the Wishbone interface to the registers.
`include "lcdid_map.svh"

module lcdid_core #(
    parameter int ADR_W    = 8,                       // wishbone address width
    parameter int OP_CYC   = `LCDID_OP_BUSY_CYC,      // busy cycles per operation
    parameter int INIT_CYC = `LCDID_INIT_CYC          // initialization cycles
) (
    input  wire logic             clk_i,                 // system clock, 100 MHz
    input  wire logic             rst_i,                 // synchronous reset, high
    input  wire logic             active_low_reset_pin_i, // reset pin, async, low
    input  wire logic             wb_cyc_i,              // wishbone cycle
    input  wire logic             wb_stb_i,              // wishbone strobe
    input  wire logic             wb_we_i,               // wishbone write enable
    input  wire logic [ADR_W-1:0] wb_adr_i,              // wishbone byte address
    input  wire logic [3:0]       wb_sel_i,              // wishbone byte lanes
    input  wire logic [31:0]      wb_dat_i,              // wishbone write data
    output logic      [31:0]      wb_dat_o,              // wishbone read data
    output logic                  wb_ack_o,              // wishbone acknowledge
    input  wire logic [5:0]       pix_com_i,             // common output index probed
    input  wire logic [7:0]       pix_seg_i,             // segment output index probed
    output logic                  pix_o,                 // pixel lit at probed point
    output logic                  panel_on_o             // panel drive enabled
);

    localparam int CNT_W = 16;
    localparam int IDX_W = 11;

    // reset pin synchroniser, first stage read only by the second
    logic pin_meta;
    logic pin_sync;
    always_ff @(posedge clk_i) begin
        pin_meta <= active_low_reset_pin_i;
        pin_sync <= pin_meta;
    end

    logic pin_low;
    assign pin_low = !pin_sync;

    // bus request decode; one action per request, ack follows a cycle later
    logic go;
    logic hit_cmd;
    logic hit_data;
    logic lane0;
    assign go       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign hit_cmd  = wb_adr_i == ADR_W'(`LCDID_ADR_CMD);
    assign hit_data = wb_adr_i == ADR_W'(`LCDID_ADR_DATA);
    assign lane0    = wb_sel_i[0];

    lcdid_pkg::lcdid_state_t state;
    logic [CNT_W-1:0]        cnt;
    logic                    busy;
    logic                    init_flag;
    logic                    serial_mode;
    assign busy      = state != lcdid_pkg::ST_READY;
    assign init_flag = state == lcdid_pkg::ST_INIT;

    // accepted actions; all are refused while busy
    // busy rejects instructions
    logic cmd_wr_go;
    logic data_wr_go;
    logic data_rd_go;
    assign cmd_wr_go  = go && wb_we_i && hit_cmd && lane0 && !busy;
    assign data_wr_go = go && wb_we_i && hit_data && lane0 && !busy;
    // no display reads in serial mode
    assign data_rd_go = go && !wb_we_i && hit_data && !busy && !serial_mode;

    // instruction decoder; anything unmatched becomes a no-op
    function automatic lcdid_pkg::lcdid_op_t decode(input logic [7:0] b);
        lcdid_pkg::lcdid_op_t op;
        op = lcdid_pkg::OP_NONE;
        unique casez (b)
            8'b1010_111?: op = lcdid_pkg::OP_DISP;
            8'b01??_????: op = lcdid_pkg::OP_LINE;
            8'b1011_????: op = lcdid_pkg::OP_PAGE;
            8'b0001_????: op = lcdid_pkg::OP_COLHI;
            8'b0000_????: op = lcdid_pkg::OP_COLLO;
            8'b1010_000?: op = lcdid_pkg::OP_ADC;
            8'b1010_011?: op = lcdid_pkg::OP_REV;
            8'b1010_010?: op = lcdid_pkg::OP_EON;
            8'b1110_0000: op = lcdid_pkg::OP_MRSET;
            8'b1110_1110: op = lcdid_pkg::OP_MRCLR;
            8'b1110_0010: op = lcdid_pkg::OP_RESET;
            8'b1100_????: op = lcdid_pkg::OP_SHL;
            8'b1110_0011: op = lcdid_pkg::OP_NOP;
            default:      op = lcdid_pkg::OP_NONE;
        endcase
        return op;
    endfunction

    logic [7:0]           ins;
    lcdid_pkg::lcdid_op_t op;
    assign ins = wb_dat_i[7:0];
    assign op  = cmd_wr_go ? decode(ins) : lcdid_pkg::OP_NONE;

    // sequencer: pin reset holds init, every accepted action is busy a while
    // reset blocks instructions
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_low) begin
            state <= lcdid_pkg::ST_INIT;
            cnt   <= CNT_W'(INIT_CYC);
        end else begin
            unique case (state)
                lcdid_pkg::ST_INIT,
                lcdid_pkg::ST_BUSY: begin
                    if (cnt <= CNT_W'(1)) begin
                        state <= lcdid_pkg::ST_READY;
                        cnt   <= '0;
                    end else begin
                        cnt <= cnt - CNT_W'(1);
                    end
                end
                lcdid_pkg::ST_READY: begin
                    if (cmd_wr_go || data_wr_go || data_rd_go) begin
                        state <= lcdid_pkg::ST_BUSY;
                        cnt   <= CNT_W'(OP_CYC);
                    end
                end
            endcase
        end
    end

    // mode bits; the pin clears them all, the reset instruction only some
    lcdid_pkg::lcdid_mode_t mode;
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_low) begin
            mode <= '0;
        end else begin
            unique case (op)
                lcdid_pkg::OP_DISP:  mode.disp_on <= ins[0];
                lcdid_pkg::OP_ADC:   mode.seg_rev <= ins[0];
                lcdid_pkg::OP_REV:   mode.invert  <= ins[0];
                lcdid_pkg::OP_EON:   mode.all_on  <= ins[0];
                lcdid_pkg::OP_SHL:   mode.com_rev <= ins[3];
                lcdid_pkg::OP_MRSET: mode.mread   <= 1'b1;
                lcdid_pkg::OP_MRCLR: mode.mread   <= 1'b0;
                lcdid_pkg::OP_RESET: begin
                    mode.mread   <= 1'b0;
                    mode.com_rev <= 1'b0;
                end
                default: mode <= mode;
            endcase
        end
    end

    // start line, page and column address
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] col_saved;
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_low || op == lcdid_pkg::OP_RESET) begin
            start_line <= '0;
            page       <= '0;
        end else if (op == lcdid_pkg::OP_LINE) begin
            start_line <= ins[5:0];
        end else if (op == lcdid_pkg::OP_PAGE && ins[3:0] <= `LCDID_LAST_PAGE) begin
            page <= ins[3:0];
        end
    end

    // column moves on loads, writes, reads outside modify-read and leaving modify-read
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_low || op == lcdid_pkg::OP_RESET) begin
            col <= '0;
        end else if (op == lcdid_pkg::OP_COLHI) begin
            col <= {ins[3:0], col[3:0]};
        end else if (op == lcdid_pkg::OP_COLLO) begin
            col <= {col[7:4], ins[3:0]};
        end else if (op == lcdid_pkg::OP_MRCLR && mode.mread) begin
            col <= col_saved;
        end else if (data_wr_go) begin
            col <= col + 8'h01;
        end else if (data_rd_go && !mode.mread) begin
            col <= col + 8'h01;
        end
    end

    // column remembered when modify-read begins, restored when it ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_saved <= '0;
        end else if (op == lcdid_pkg::OP_MRSET && !mode.mread) begin
            col_saved <= col;
        end
    end

    // control register; serial mode only matters for display reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_mode <= 1'b0;
        end else if (go && wb_we_i && lane0 && wb_adr_i == ADR_W'(`LCDID_ADR_CTRL)) begin
            serial_mode <= wb_dat_i[`LCDID_CT_SERIAL];
        end
    end

    // display ram, page major; no reset so contents survive every reset
    logic [7:0]       ram [0:`LCDID_PAGES*`LCDID_COLS-1];
    logic [IDX_W-1:0] host_idx;
    logic             host_in_range;
    assign host_idx      = IDX_W'(page) * IDX_W'(`LCDID_COLS) + IDX_W'(col);
    assign host_in_range = col <= `LCDID_LAST_SEG;

    always_ff @(posedge clk_i) begin
        if (data_wr_go && host_in_range) begin
            ram[host_idx] <= ins;
        end
    end

    // read latch: a read returns what the previous read fetched, which is
    // why the first read after an address load is a dummy
    // dummy read pipeline
    logic [7:0] rd_latch;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_latch <= '0;
        end else if (data_rd_go) begin
            rd_latch <= host_in_range ? ram[host_idx] : 8'h00;
        end
    end

    // status byte
    // status layout
    logic [7:0] status;
    always_comb begin
        status                   = 8'h00;
        status[`LCDID_ST_BUSY]   = busy;
        status[`LCDID_ST_DIR]    = !mode.seg_rev;
        status[`LCDID_ST_OFF]    = !mode.disp_on;
        status[`LCDID_ST_RST]    = init_flag;
    end

    // read mux; unmapped addresses answer zero
    logic [31:0] next_dat;
    always_comb begin
        next_dat = 32'h0000_0000;
        if (hit_cmd) begin
            next_dat[7:0] = status;
        end else if (hit_data) begin
            next_dat[7:0] = data_rd_go ? rd_latch : 8'h00;
        end else if (wb_adr_i == ADR_W'(`LCDID_ADR_MODE)) begin
            next_dat[5:0] = mode;
        end else if (wb_adr_i == ADR_W'(`LCDID_ADR_ADDR)) begin
            next_dat[7:0]                       = col;
            next_dat[`LCDID_AD_PAGE_LO +: 4]    = page;
            next_dat[`LCDID_AD_LINE_LO +: 6]    = start_line;
        end else if (wb_adr_i == ADR_W'(`LCDID_ADR_CTRL)) begin
            next_dat[`LCDID_CT_SERIAL] = serial_mode;
        end
    end

    // ack one cycle after the request is seen, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= go;
            if (go && !wb_we_i) begin
                wb_dat_o <= next_dat;
            end
        end
    end

    // panel view: map the probed common and segment to a ram bit
    // top row follows common direction
    logic [5:0]       row;
    logic [5:0]       line;
    logic [7:0]       pcol;
    logic [IDX_W-1:0] pix_idx;
    logic [7:0]       pix_byte;
    logic             ram_bit;
    assign row      = mode.com_rev ? (`LCDID_LAST_COM - pix_com_i) : pix_com_i;
    assign line     = row + start_line;
    assign pcol     = mode.seg_rev ? (`LCDID_LAST_SEG - pix_seg_i) : pix_seg_i;
    assign pix_idx  = IDX_W'(line[5:3]) * IDX_W'(`LCDID_COLS) + IDX_W'(pcol);
    assign pix_byte = (pix_seg_i <= `LCDID_LAST_SEG) ? ram[pix_idx] : 8'h00;
    assign ram_bit  = pix_byte[line[2:0]];

    // pixel output; page register takes no part here, so page loads are
    // invisible on the panel
    // page independent view
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pix_o      <= 1'b0;
            panel_on_o <= 1'b0;
        end else begin
            pix_o      <= mode.disp_on && (mode.all_on || (ram_bit ^ mode.invert));
            panel_on_o <= mode.disp_on;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_lit_all;
        mode.all_on && mode.disp_on;
    endsequence

    sequence s_dark;
        !mode.disp_on;
    endsequence

    a_write_col_inc: assert property (data_wr_go |=> col == $past(col) + 8'h01)
        else $error("column did not advance after write");
    a_read_col_inc: assert property (data_rd_go && !mode.mread |=> col == $past(col) + 8'h01)
        else $error("column did not advance after read");
    a_mread_col_hold: assert property (data_rd_go && mode.mread |=> $stable(col))
        else $error("column moved on modify-read read");
    a_busy_refuse: assert property (go && busy && wb_we_i && hit_cmd |=>
        ($stable(mode) && $stable(start_line) && $stable(page)) || $past(pin_low))
        else $error("action accepted while busy");
    a_busy_window: assert property (cmd_wr_go |=> busy [*2])
        else $error("busy not held after instruction");
    a_status_flags: assert property (go && !wb_we_i && hit_cmd |=> wb_dat_o[3:0] == 4'h0 && wb_dat_o[`LCDID_ST_BUSY] == $past(busy))
        else $error("status byte wrong");
    a_off_flag: assert property (go && !wb_we_i && hit_cmd |=> wb_dat_o[`LCDID_ST_OFF] == !$past(mode.disp_on))
        else $error("display flag wrong");
    a_pin_clears: assert property (pin_low |=> col == 8'h00 && page == 4'h0 && start_line == 6'h00 && init_flag)
        else $error("pin reset did not clear addresses");
    a_page_quiet: assert property (op == lcdid_pkg::OP_PAGE |=> $stable(mode) && $stable(start_line))
        else $error("page load disturbed display state");
    a_all_on_wins: assert property (s_lit_all [*2] |-> pix_o)
        else $error("all points on did not light pixel");
    a_blank_off: assert property (s_dark [*2] |-> !pix_o && !panel_on_o)
        else $error("pixel lit with display off");
    a_serial_noread: assert property (serial_mode && go && !wb_we_i && hit_data |=>
        wb_dat_o[7:0] == 8'h00 && ($stable(col) || $past(pin_low)))
        else $error("display read in serial mode");

endmodule // lcdid_core

// ==== hdl/lcdid_map.svh ====
`ifndef LCDID_MAP_SVH
`define LCDID_MAP_SVH

// wishbone byte offsets of the register window
`define LCDID_ADR_CMD      8'h00
`define LCDID_ADR_DATA     8'h04
`define LCDID_ADR_MODE     8'h08
`define LCDID_ADR_ADDR     8'h0C
`define LCDID_ADR_CTRL     8'h10

// status byte layout
`define LCDID_ST_BUSY      7
`define LCDID_ST_DIR       6
`define LCDID_ST_OFF       5
`define LCDID_ST_RST       4

// mode readback layout
`define LCDID_MD_DISP      0
`define LCDID_MD_INV       1
`define LCDID_MD_ALL       2
`define LCDID_MD_SEG       3
`define LCDID_MD_COM       4
`define LCDID_MD_MREAD     5

// address readback layout
`define LCDID_AD_PAGE_LO   8
`define LCDID_AD_LINE_LO   16

// control register layout
`define LCDID_CT_SERIAL    0

// display ram geometry
`define LCDID_PAGES        9
`define LCDID_COLS         132
`define LCDID_LAST_PAGE    4'h8
`define LCDID_LAST_COM     6'h3F
`define LCDID_LAST_SEG     8'h83

// timing: figures in ns, counts derived from the clock period
`define LCDID_CLK_NS       10
`define LCDID_OP_BUSY_NS   20
`define LCDID_INIT_NS      1000
`define LCDID_OP_BUSY_CYC  ((`LCDID_OP_BUSY_NS + `LCDID_CLK_NS - 1) / `LCDID_CLK_NS)
`define LCDID_INIT_CYC     ((`LCDID_INIT_NS + `LCDID_CLK_NS - 1) / `LCDID_CLK_NS)

`endif

// ==== hdl/lcdid_pkg.sv ====
package lcdid_pkg;

    // decoded instruction kinds
    typedef enum logic [3:0] {
        OP_NONE, OP_DISP, OP_LINE, OP_PAGE, OP_COLHI, OP_COLLO, OP_ADC,
        OP_REV, OP_EON, OP_MRSET, OP_MRCLR, OP_RESET, OP_SHL, OP_NOP
    } lcdid_op_t;

    // display mode bits that travel together
    typedef struct packed {
        logic mread;        // modify-read active
        logic com_rev;      // common direction select
        logic seg_rev;      // segment direction select
        logic all_on;       // all points on
        logic invert;       // invert display
        logic disp_on;      // display enable
    } lcdid_mode_t;

    // sequencer states
    typedef enum logic [1:0] {ST_INIT, ST_READY, ST_BUSY} lcdid_state_t;

endpackage : lcdid_pkg

// ==== testbench/lcdid_core_tb.sv ====
`include "lcdid_map.svh"

module lcdid_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pin_n = 1'b0;
    logic        cyc, stb, we, ack, pix, panel;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, r;
    logic [5:0]  com = 6'h00;
    logic [7:0]  seg = 8'h00;
    int          mismatches = 0;
    int          num_checks = 0;
    bit          ok;

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    // short init count keeps the run brief
    lcdid_core #(.INIT_CYC(4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .active_low_reset_pin_i(pin_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pix_com_i(com), .pix_seg_i(seg), .pix_o(pix), .panel_on_o(panel));

    lcdid_host host_u (
        .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
        .wb_sel_o(sel), .wb_dat_o(wdat), .wb_ack_i(ack), .wb_dat_i(rdat));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a hung bus ends the run
    task automatic bail();
        if (!ok) begin
            mismatches++;
            $display("ERROR at %0t: bus wait ran out", $time);
            end_of_test();
        end
    endtask

    function automatic logic [31:0] addr(input logic [5:0] l, input logic [3:0] p,
                                         input logic [7:0] c);
        return {10'h000, l, 4'h0, p, c};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d, r, ok);
        bail();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host_u.access(1'b0, a, 8'h00, r, ok);
        bail();
        chk(r, e);
    endtask
    task automatic rdy();
        host_u.ready(ok);
        bail();
    endtask
    task automatic ins(input logic [7:0] c);
        host_u.instr(c, ok);
        bail();
    endtask
    task automatic col(input logic [7:0] c);
        host_u.column(c, ok);
        bail();
    endtask
    task automatic dw(input logic [7:0] d);
        rdy();
        wr(`LCDID_ADR_DATA, d);
    endtask
    // data read; the compare is skipped for a discarded read
    task automatic dr(input logic [31:0] e, input bit c);
        rdy();
        host_u.access(1'b0, `LCDID_ADR_DATA, 8'h00, r, ok);
        bail();
        if (c) chk(r, e);
    endtask
    // pixel output lags the probe by one registered stage
    task automatic px(input logic [5:0] c, input logic [7:0] s, input logic e);
        @(posedge clk_i);
        com <= c;
        seg <= s;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk({31'h0, pix}, {31'h0, e});
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(`LCDID_ADR_CMD, 32'h0000_00F0);
        wr(`LCDID_ADR_CMD, 8'hAF);
        @(posedge clk_i);
        pin_n <= 1'b1;
        rdy();
        rd(`LCDID_ADR_CMD, 32'h0000_0060);
        rd(`LCDID_ADR_MODE, 32'h0000_0000);
        rd(`LCDID_ADR_ADDR, 32'h0000_0000);
        ins(8'hAF);
        rdy();
        rd(`LCDID_ADR_CMD, 32'h0000_0040);
        chk({31'h0, panel}, 32'h1);
        ins(8'hB8);
        col(8'h83);
        ins(8'hB9);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h8, 8'h83));
        dw(8'hA5);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h8, 8'h84));
        col(8'h83);
        dr(32'h0, 1'b0);
        dr(32'h0000_00A5, 1'b1);
        ins(8'hB0);
        col(8'h05);
        dw(8'h11);
        dw(8'h22);
        dw(8'h33);
        col(8'h05);
        dr(32'h0, 1'b0);
        dr(32'h0000_0011, 1'b1);
        dr(32'h0000_0022, 1'b1);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h08));
        ins(8'hE0);
        rd(`LCDID_ADR_MODE, 32'h0000_0021);
        dr(32'h0, 1'b0);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h08));
        dw(8'h44);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h09));
        ins(8'hEE);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h08));
        // serial mode: display data must not come back
        wr(`LCDID_ADR_CTRL, 8'h01);
        col(8'h05);
        dr(32'h0, 1'b1);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h05));
        wr(`LCDID_ADR_CTRL, 8'h00);
        ins(8'h80);
        ins(8'hE3);
        rdy();
        rd(`LCDID_ADR_MODE, 32'h0000_0001);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h05));
        // panel view of line 0, column 0; last column of page 0 cleared so reversed reads are known
        col(8'h83);
        dw(8'h00);
        col(8'h00);
        dw(8'h01);
        px(6'd0, 8'd0, 1'b1);
        px(6'd1, 8'd0, 1'b0);
        ins(8'hA7);
        px(6'd0, 8'd0, 1'b0);
        ins(8'hA5);
        px(6'd0, 8'd0, 1'b1);
        ins(8'hA4);
        ins(8'hA6);
        px(6'd0, 8'd0, 1'b1);
        ins(8'hA1);
        px(6'd0, 8'd131, 1'b1);
        px(6'd0, 8'd0, 1'b0);
        rdy();
        rd(`LCDID_ADR_CMD, 32'h0000_0000);
        ins(8'h41);
        px(6'd63, 8'd131, 1'b1);
        px(6'd0, 8'd131, 1'b0);
        ins(8'hC8);
        px(6'd0, 8'd131, 1'b1);
        ins(8'hB3);
        px(6'd0, 8'd131, 1'b1);
        ins(8'hAE);
        px(6'd0, 8'd131, 1'b0);
        chk({31'h0, panel}, 32'h0);
        // reset instruction: addresses and common direction cleared, segment direction kept
        ins(8'hE2);
        rdy();
        rd(`LCDID_ADR_MODE, 32'h0000_0008);
        rd(`LCDID_ADR_ADDR, addr(6'h00, 4'h0, 8'h00));
        // mid-run reset pulse; an instruction sent during initialization is refused
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        wr(`LCDID_ADR_CMD, 8'hA7);
        rdy();
        rd(`LCDID_ADR_MODE, 32'h0000_0000);
        end_of_test();
    end
endmodule // lcdid_core_tb

// ==== testbench/lcdid_host.sv ====
`include "lcdid_map.svh"

// host processor model: classic wishbone master plus the host-side habits
module lcdid_host (
    input  wire logic        clk_i,    // system clock
    output logic             wb_cyc_o, // cycle
    output logic             wb_stb_o, // strobe
    output logic             wb_we_o,  // write enable
    output logic [7:0]       wb_adr_o, // byte address
    output logic [3:0]       wb_sel_o, // byte lanes
    output logic [31:0]      wb_dat_o, // write data
    input  wire logic        wb_ack_i, // acknowledge
    input  wire logic [31:0] wb_dat_i  // read data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // one single cycle; the request stands until the rising edge that samples ack high,
    // read data is taken at that edge and the release follows it by non-blocking assignment
    task automatic access(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                          output logic [31:0] rdat, output bit ok);
        int n;
        ok   = 1'b0;
        rdat = 32'h0000_0000;
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hF;
        wb_dat_o <= {24'h000000, dat};
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk_i);
            ok = (wb_ack_i === 1'b1);
            if (ok) rdat = wb_dat_i;
        end
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_dat_o <= ~wb_dat_o; // stale data must not look valid
    endtask

    task automatic ready(output bit ok);
        logic [31:0] st;
        int          n;
        st = 32'h0000_0080;
        ok = 1'b1;
        for (n = 0; n < 200 && ok && st[7] !== 1'b0; n++) begin
            access(1'b0, `LCDID_ADR_CMD, 8'h00, st, ok);
        end
        if (st[7] !== 1'b0) ok = 1'b0;
    endtask

    task automatic instr(input logic [7:0] code, output bit ok);
        logic [31:0] r;
        ready(ok);
        if (ok && code[7:4] != 4'hF && code[7:4] != 4'h9) begin
            access(1'b1, `LCDID_ADR_CMD, code, r, ok);
        end
    endtask

    task automatic column(input logic [7:0] c, output bit ok);
        instr({4'h1, c[7:4]}, ok);
        if (ok) instr({4'h0, c[3:0]}, ok);
    endtask
endmodule // lcdid_host
